// ### core_defs.svh
/*
  Offsets, field positions, reset values and state counts of the
  execution slice. Assumes inclusion before the package users.
*/
`ifndef CORE_DEFS_SVH
`define CORE_DEFS_SVH
// ----------------------------------------
// Register map
// ----------------------------------------
`define WB_CTRL 8'h00
`define WB_PC 8'h04
`define WB_STAT 8'h08
`define WB_VBR 8'h0c
`define WB_PR 8'h10
`define WB_SR 8'h14
`define WB_GPR_HI 2'h1
`define CTRL_RUN 0
`define CTRL_STBY 1
`define STAT_T 0
`define STAT_SLEEP 1
`define STAT_RUN 2
`define STAT_SLOT 3
`define T_BIT 0
`define SR_RESET 32'h0000_0000
`define PC_RESET 32'h0000_0000
`define SP_IDX 4'hf
// ----------------------------------------
// Least execution states
// ----------------------------------------
`define N_ONE 4'h1
`define N_DELAYED 4'h2
`define N_BCOND_TAKEN 4'h3
`define N_BFS_TAKEN 4'h3
`define N_BTS_TAKEN 4'h2
`define N_RTE 4'h4
`define N_TRAP 4'h8
`define N_LDC_MEM 4'h3
`define N_STC_MEM 4'h2
`define N_SLEEP 4'h3
`endif

// ### core_pkg.sv
/*
  Types of the execution slice: operations, sequencer states and
  the state records. Assumes nothing of its surroundings.
*/
package core_pkg;
  typedef enum logic [4:0] {
    OP_NOP, OP_SHIFT, OP_BF, OP_BT, OP_BFS, OP_BTS, OP_BRA, OP_REGISTER_RELATIVE_JUMP,
    OP_BSR, OP_CALL_REGISTER_RELATIVE, OP_JMP, OP_JSR, OP_RTS, OP_RTE, OP_TRAP, OP_LDM,
    OP_STM, OP_LDR, OP_STR, OP_CLRT, OP_SETT, OP_CLRMAC, OP_SLEEP
  } op_e;
  typedef enum logic [2:0] {ST_HALT, ST_FETCH, ST_READ, ST_EXEC, ST_SLEEP} state_e;
  typedef struct packed {
    state_e state;
    logic [31:0] pc;
    logic [15:0] instr;
    logic [31:0] sr;
    logic [31:0] global_base_reg;
    logic [31:0] vector_base_reg;
    logic [31:0] pr;
    logic [31:0] mac_high;
    logic [31:0] mac_low;
    logic [3:0] cnt;
    logic [1:0] step;
    logic slot;
    logic [31:0] slot_pc;
    logic [31:0] tmp;
    logic [31:0] ld;
    logic haz;
    logic [2:0] haz_idx;
    logic haz_wait;
    logic sleep;
    logic standby;
    logic mem_req;
    logic mem_we;
    logic [31:0] mem_addr;
    logic [31:0] mem_wdata;
  } core_s;
  typedef struct packed {
    logic run;
    logic stby;
    logic ack;
    logic err;
    logic [31:0] dat;
  } wb_s;
endpackage

// ### gpr_if.sv
/*
  General register file port between the sequencer and the store.
  Assumes one writer and a registered read.
*/
`timescale 1ns/1ps
interface gpr_if #(
  parameter int W = 32,
  parameter int AW = 4
);
  logic [AW-1:0] rd_idx;
  logic [W-1:0] rd_data;
  logic wr_en;
  logic [AW-1:0] wr_idx;
  logic [W-1:0] wr_data;
  modport core (output rd_idx, output wr_en, output wr_idx, output wr_data, input rd_data);
  modport store (input rd_idx, input wr_en, input wr_idx, input wr_data, output rd_data);
endinterface

// ### gpr_file.sv
/*
  Sixteen general registers, one write port, one registered read.
  Assumes the reader waits one clock for read data.
*/
`timescale 1ns/1ps
module gpr_file #(
  parameter int DEPTH = 16
) (
  input wire logic i_clk,
  gpr_if.store port
);
  logic [31:0] mem [DEPTH];
  logic [31:0] next_rd;

  if (DEPTH != 16) begin : g_chk
    $error("gpr_file needs DEPTH of 16");
  end

  always_comb begin
    next_rd = mem[port.rd_idx];
  end

  always_ff @(posedge i_clk) begin
    if (port.wr_en) begin
      mem[port.wr_idx] <= port.wr_data;
    end
    port.rd_data <= next_rd;
  end
endmodule

// ### shift_branch_sysctl_exec.sv
/*
  Execution slice for shift, branch and system-control instructions.
  Assumes a word memory with req/ack for fetch and data, a classic
  Wishbone master for control, and inputs synchronous to i_clk.
*/
// Our own choices: the register addresses and the Wishbone slave port.
`timescale 1ns/1ps
`include "core_defs.svh"
module shift_branch_sysctl_exec
  import core_pkg::*;
#(
  parameter int NUM_GPR = 16
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [7:0] i_wb_adr,
  input wire logic [3:0] i_wb_sel,
  input wire logic [31:0] i_wb_dat,
  output logic [31:0] o_wb_dat,
  output logic o_wb_ack,
  output logic o_wb_err,
  output logic o_mem_req,
  output logic o_mem_we,
  output logic [31:0] o_mem_addr,
  output logic [31:0] o_mem_wdata,
  input wire logic i_mem_ack,
  input wire logic [31:0] i_mem_rdata,
  input wire logic i_wake,
  output logic o_sleep,
  output logic o_standby
);
  // ----------------------------------------
  // Decode helpers
  // ----------------------------------------
  function automatic op_e decode(input logic [15:0] i);
    op_e o;
    casez (i)
      16'b0100????000?010?, 16'b0100????0010010?, 16'b0100????0010000?, 16'b0100????0000000?,
      16'b0100????0000100?, 16'b0100????0001100?, 16'b0100????0010100?: o = OP_SHIFT;
      16'b10001011????????: o = OP_BF;
      16'b10001001????????: o = OP_BT;
      16'b10001111????????: o = OP_BFS;
      16'b10001101????????: o = OP_BTS;
      16'b1010????????????: o = OP_BRA;
      16'b1011????????????: o = OP_BSR;
      16'b0000????00100011: o = OP_REGISTER_RELATIVE_JUMP;
      16'b0000????00000011: o = OP_CALL_REGISTER_RELATIVE;
      16'b0100????00101011: o = OP_JMP;
      16'b0100????00001011: o = OP_JSR;
      16'h000b: o = OP_RTS;
      16'h002b: o = OP_RTE;
      16'b11000011????????: o = OP_TRAP;
      16'b0100????00??011?: o = OP_LDM;
      16'b0100????00??001?: o = OP_STM;
      16'b0100????00??1110, 16'b0100????00??1010: o = OP_LDR;
      16'b0000????00??0010, 16'b0000????00??1010: o = OP_STR;
      16'h0008: o = OP_CLRT;
      16'h0018: o = OP_SETT;
      16'h0028: o = OP_CLRMAC;
      16'h001b: o = OP_SLEEP;
      default: o = OP_NOP;
    endcase
    if (o inside {OP_LDM, OP_STM, OP_LDR, OP_STR} && i[5:4] == 2'h3) begin
      o = OP_NOP;
    end
    return o;
  endfunction

  function automatic logic [2:0] sys_idx(input op_e o, input logic [15:0] i);
    logic ctl;
    ctl = (o == OP_LDR) ? i[2] : (o == OP_STR) ? !i[3] : i[0];
    return ctl ? {1'h0, i[5:4]} : 3'({1'h0, i[5:4]} + 3'h3);
  endfunction

  function automatic logic [31:0] sys_rd(input core_s s, input logic [2:0] x);
    case (x)
      3'h0: return s.sr;
      3'h1: return s.global_base_reg;
      3'h2: return s.vector_base_reg;
      3'h3: return s.mac_high;
      3'h4: return s.mac_low;
      default: return s.pr;
    endcase
  endfunction

  // Returns {new flag, new value}
  function automatic logic [32:0] shift_op(input logic [7:0] f, input logic [31:0] v, input logic t);
    case (f)
      8'h04: return {v[31], v[30:0], v[31]};
      8'h05: return {v[0], v[0], v[31:1]};
      8'h24: return {v[31], v[30:0], t};
      8'h25: return {v[0], t, v[31:1]};
      8'h00, 8'h20: return {v[31], v[30:0], 1'h0};
      8'h21: return {v[0], v[31], v[31:1]};
      8'h01: return {v[0], 1'h0, v[31:1]};
      8'h08: return {t, v[29:0], 2'h0};
      8'h09: return {t, 2'h0, v[31:2]};
      8'h18: return {t, v[23:0], 8'h00};
      8'h19: return {t, 8'h00, v[31:8]};
      8'h28: return {t, v[15:0], 16'h0000};
      8'h29: return {t, 16'h0000, v[31:16]};
      default: return {t, v};
    endcase
  endfunction

  function automatic logic [3:0] min_states(input op_e o, input logic tk, input logic ctl);
    case (o)
      OP_BF, OP_BT: return tk ? `N_BCOND_TAKEN : `N_ONE;
      OP_BFS: return tk ? `N_BFS_TAKEN : `N_ONE;
      OP_BTS: return tk ? `N_BTS_TAKEN : `N_ONE;
      OP_BRA, OP_REGISTER_RELATIVE_JUMP, OP_BSR, OP_CALL_REGISTER_RELATIVE, OP_JMP, OP_JSR, OP_RTS: return `N_DELAYED;
      OP_RTE: return `N_RTE;
      OP_TRAP: return `N_TRAP;
      OP_LDM: return ctl ? `N_LDC_MEM : `N_ONE;
      OP_STM: return ctl ? `N_STC_MEM : `N_ONE;
      OP_SLEEP: return `N_SLEEP;
      default: return `N_ONE;
    endcase
  endfunction

  if (NUM_GPR != 16) begin : g_chk
    $error("NUM_GPR must be 16");
  end

  // ----------------------------------------
  // State and operands
  // ----------------------------------------
  core_s c, next_c;
  wb_s w, next_w;
  gpr_if rf ();
  gpr_file #(.DEPTH(NUM_GPR)) u_gpr (.i_clk(i_clk), .port(rf));

  op_e op;
  logic [2:0] sidx;
  logic [31:0] opnd, sysval, pc4, disp8, disp12, target;
  logic t, taken, dly, retire, acc_we, wb_wr, halted;
  logic [1:0] nsteps;
  logic [3:0] need;
  logic [31:0] acc_addr, acc_wdata;
  logic [32:0] sh;

  always_comb begin
    op = decode(c.instr);
    sidx = sys_idx(op, c.instr);
    sysval = sys_rd(c, sidx);
    opnd = rf.rd_data;
    t = c.sr[`T_BIT];
    pc4 = c.pc + 32'h4;
    disp8 = {{23{c.instr[7]}}, c.instr[7:0], 1'h0};
    disp12 = {{19{c.instr[11]}}, c.instr[11:0], 1'h0};
    sh = shift_op(c.instr[7:0], opnd, t);
    halted = c.state == ST_HALT;
    wb_wr = i_wb_cyc && i_wb_stb && i_wb_we && w.ack;
    case (op)
      OP_BF, OP_BFS: taken = !t;
      OP_BT, OP_BTS: taken = t;
      OP_BRA, OP_REGISTER_RELATIVE_JUMP, OP_BSR, OP_CALL_REGISTER_RELATIVE, OP_JMP, OP_JSR, OP_RTS, OP_RTE, OP_TRAP: taken = 1'h1;
      default: taken = 1'h0;
    endcase
    dly = op inside {OP_BFS, OP_BTS, OP_BRA, OP_REGISTER_RELATIVE_JUMP, OP_BSR, OP_CALL_REGISTER_RELATIVE, OP_JMP, OP_JSR, OP_RTS, OP_RTE};
    case (op)
      OP_BRA, OP_BSR: target = pc4 + disp12;
      OP_REGISTER_RELATIVE_JUMP, OP_CALL_REGISTER_RELATIVE: target = pc4 + opnd;
      OP_JMP, OP_JSR: target = opnd;
      OP_RTS: target = c.pr;
      OP_RTE: target = c.tmp;
      OP_TRAP: target = c.ld;
      default: target = pc4 + disp8;
    endcase
    nsteps = (op == OP_TRAP) ? 2'h3 : (op == OP_RTE) ? 2'h2 : (op inside {OP_LDM, OP_STM}) ? 2'h1 : 2'h0;
    need = min_states(op, taken, sidx < 3'h3);
    // Counts are floors; extra bus wait only adds states
    retire = c.state == ST_EXEC && c.step == nsteps && c.cnt >= need - 4'h1;
    acc_we = 1'h0;
    acc_wdata = sysval;
    acc_addr = opnd;
    case (op)
      OP_STM: begin
        acc_we = 1'h1;
        acc_addr = opnd - 32'h4;
      end
      OP_RTE: acc_addr = (c.step == 2'h0) ? opnd : opnd + 32'h4;
      OP_TRAP: begin
        acc_we = c.step != 2'h2;
        acc_addr = (c.step == 2'h0) ? opnd - 32'h4 : (c.step == 2'h1) ? opnd - 32'h8
          : c.vector_base_reg + {22'h0, c.instr[7:0], 2'h0};
        acc_wdata = (c.step == 2'h0) ? c.sr : c.pc + 32'h2;
      end
      default: ;
    endcase
  end

  // ----------------------------------------
  // Register file port
  // ----------------------------------------
  always_comb begin
    rf.rd_idx = (op inside {OP_RTE, OP_TRAP}) ? `SP_IDX : c.instr[11:8];
    rf.wr_idx = halted ? i_wb_adr[5:2] : rf.rd_idx;
    rf.wr_en = 1'h0;
    rf.wr_data = i_wb_dat;
    if (halted) begin
      rf.wr_en = wb_wr && i_wb_adr[7:6] == `WB_GPR_HI && i_wb_sel == 4'hf;
    end else if (retire) begin
      rf.wr_en = op inside {OP_SHIFT, OP_LDM, OP_STM, OP_STR, OP_RTE, OP_TRAP};
      case (op)
        OP_SHIFT: rf.wr_data = sh[31:0];
        OP_LDM: rf.wr_data = opnd + 32'h4;
        OP_STM: rf.wr_data = opnd - 32'h4;
        OP_RTE: rf.wr_data = opnd + 32'h8;
        OP_TRAP: rf.wr_data = opnd - 32'h8;
        default: rf.wr_data = sysval;
      endcase
    end
  end

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  always_comb begin
    next_c = c;
    if (c.mem_req && i_mem_ack) begin
      next_c.mem_req = 1'h0;
      next_c.mem_we = 1'h0;
    end else if (!c.mem_req && ((c.state == ST_FETCH && w.run) || (c.state == ST_EXEC && c.step < nsteps))) begin
      // One port for fetch and data, so each waits for the other
      next_c.mem_req = 1'h1;
      next_c.mem_we = c.state == ST_EXEC && acc_we;
      next_c.mem_addr = (c.state == ST_FETCH) ? {c.pc[31:2], 2'h0} : acc_addr;
      next_c.mem_wdata = acc_wdata;
    end
    unique case (c.state)
      ST_HALT: begin
        if (wb_wr && i_wb_adr == `WB_PC && i_wb_sel == 4'hf) begin
          next_c.pc = i_wb_dat;
          next_c.slot = 1'h0;
        end
        if (w.run) begin
          next_c.state = ST_FETCH;
        end
      end
      ST_FETCH: begin
        if (c.mem_req && i_mem_ack) begin
          next_c.instr = c.pc[1] ? i_mem_rdata[15:0] : i_mem_rdata[31:16];
          next_c.state = ST_READ;
          next_c.cnt = 4'h0;
          next_c.step = 2'h0;
        end else if (!c.mem_req && !w.run) begin
          next_c.state = ST_HALT;
        end
      end
      ST_READ: begin
        if (c.haz && !c.haz_wait && op inside {OP_STM, OP_STR} && sidx == c.haz_idx) begin
          next_c.haz_wait = 1'h1;
        end else begin
          next_c.haz = 1'h0;
          next_c.haz_wait = 1'h0;
          next_c.state = ST_EXEC;
        end
      end
      ST_EXEC: begin
        if (c.cnt != 4'hf) begin
          next_c.cnt = c.cnt + 4'h1;
        end
        if (c.mem_req && i_mem_ack) begin
          next_c.step = c.step + 2'h1;
          if (op == OP_RTE && c.step == 2'h0) begin
            next_c.tmp = i_mem_rdata;
          end else begin
            next_c.ld = i_mem_rdata;
          end
        end
        if (retire) begin
          next_c.state = ST_FETCH;
          case (op)
            OP_SHIFT: next_c.sr[`T_BIT] = sh[32];
            OP_CLRT: next_c.sr[`T_BIT] = 1'h0;
            OP_SETT: next_c.sr[`T_BIT] = 1'h1;
            OP_RTE: next_c.sr = c.ld;
            OP_CLRMAC: begin
              next_c.mac_high = 32'h0;
              next_c.mac_low = 32'h0;
            end
            OP_BSR, OP_CALL_REGISTER_RELATIVE, OP_JSR: next_c.pr = pc4;
            OP_SLEEP: begin
              next_c.state = ST_SLEEP;
              next_c.sleep = 1'h1;
              next_c.standby = w.stby;
            end
            default: ;
          endcase
          if (op inside {OP_LDM, OP_LDR}) begin
            case (sidx)
              3'h0: next_c.sr = (op == OP_LDM) ? c.ld : opnd;
              3'h1: next_c.global_base_reg = (op == OP_LDM) ? c.ld : opnd;
              3'h2: next_c.vector_base_reg = (op == OP_LDM) ? c.ld : opnd;
              3'h3: next_c.mac_high = (op == OP_LDM) ? c.ld : opnd;
              3'h4: next_c.mac_low = (op == OP_LDM) ? c.ld : opnd;
              default: next_c.pr = (op == OP_LDM) ? c.ld : opnd;
            endcase
            next_c.haz = op == OP_LDM;
            next_c.haz_idx = sidx;
          end
          if (c.slot) begin
            next_c.pc = c.slot_pc;
            next_c.slot = 1'h0;
          end else if (taken && dly) begin
            next_c.pc = c.pc + 32'h2;
            next_c.slot = 1'h1;
            next_c.slot_pc = target;
          end else if (taken) begin
            next_c.pc = target;
          end else begin
            next_c.pc = c.pc + 32'h2;
          end
        end
      end
      ST_SLEEP: begin
        if (i_wake) begin
          next_c.state = ST_FETCH;
          next_c.sleep = 1'h0;
          next_c.standby = 1'h0;
        end
      end
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      c <= '0;
      c.state <= ST_HALT;
      c.pc <= `PC_RESET;
      c.sr <= `SR_RESET;
    end else begin
      c <= next_c;
    end
  end

  // ----------------------------------------
  // Wishbone slave
  // ----------------------------------------
  always_comb begin
    next_w = w;
    next_w.ack = 1'h0;
    next_w.err = 1'h0;
    if (i_wb_cyc && i_wb_stb && !w.ack && !w.err) begin
      next_w.ack = 1'h1;
      next_w.dat = 32'h0;
      case (i_wb_adr)
        `WB_CTRL: begin
          next_w.dat[`CTRL_RUN] = w.run;
          next_w.dat[`CTRL_STBY] = w.stby;
        end
        `WB_PC: next_w.dat = c.pc;
        `WB_STAT: begin
          next_w.dat[`STAT_T] = c.sr[`T_BIT];
          next_w.dat[`STAT_SLEEP] = c.sleep;
          next_w.dat[`STAT_RUN] = !halted;
          next_w.dat[`STAT_SLOT] = c.slot;
        end
        `WB_VBR: next_w.dat = c.vector_base_reg;
        `WB_PR: next_w.dat = c.pr;
        `WB_SR: next_w.dat = c.sr;
        default: begin
          next_w.ack = i_wb_adr[7:6] == `WB_GPR_HI && i_wb_adr[1:0] == 2'h0;
          next_w.err = !next_w.ack;
        end
      endcase
    end
    if (wb_wr && i_wb_adr == `WB_CTRL && i_wb_sel[0]) begin
      next_w.run = i_wb_dat[`CTRL_RUN];
      next_w.stby = i_wb_dat[`CTRL_STBY];
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      w <= '0;
    end else begin
      w <= next_w;
    end
  end

  always_comb begin
    o_wb_dat = w.dat;
    o_wb_ack = w.ack;
    o_wb_err = w.err;
    o_mem_req = c.mem_req;
    o_mem_we = c.mem_we;
    o_mem_addr = c.mem_addr;
    o_mem_wdata = c.mem_wdata;
    o_sleep = c.sleep;
    o_standby = c.standby;
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_n);

  sequence s_dly_taken;
    retire && dly && taken && !c.slot;
  endsequence
  sequence s_slot_done;
    c.state == ST_EXEC && retire && c.slot;
  endsequence
  sequence s_halt_early;
    halted;
  endsequence

  a_rotate_left_flag: assert property (retire && op == OP_SHIFT && c.instr[7:0] == 8'h04
    |=> c.sr[`T_BIT] == $past(rf.rd_data[31])) else $error("rotate left flag wrong");
  a_rotate_right_through_flag_flag: assert property (retire && op == OP_SHIFT && c.instr[7:0] == 8'h25
    |=> c.sr[`T_BIT] == $past(rf.rd_data[0])) else $error("rotate right through flag wrong");
  a_multi_keeps_t: assert property (retire && op == OP_SHIFT && c.instr[3]
    |=> $stable(c.sr[`T_BIT])) else $error("multi-bit shift touched flag");
  a_bf_taken_pc: assert property (retire && op == OP_BF && !t && !c.slot
    |-> c.cnt >= 4'h2 ##1 c.pc == $past(c.pc) + 32'h4 + disp8) else $error("branch if clear wrong");
  a_trap_states: assert property (retire && op == OP_TRAP |-> c.cnt >= 4'h7)
    else $error("trap too short");
  a_rte_states: assert property (retire && op == OP_RTE |-> c.cnt >= 4'h3)
    else $error("exception return too short");
  a_slot_order: assert property (s_dly_taken |=> c.slot && c.pc == $past(c.pc) + 32'h2
    ##[1:300] (s_slot_done or s_halt_early)) else $error("delay slot skipped");
  a_call_return: assert property (retire && op inside {OP_BSR, OP_CALL_REGISTER_RELATIVE, OP_JSR}
    |=> c.pr == $past(c.pc) + 32'h4) else $error("return address wrong");
  a_sleep_entry: assert property (retire && op == OP_SLEEP |-> c.cnt >= 4'h2
    ##1 c.state == ST_SLEEP && o_sleep) else $error("sleep entry wrong");
  a_load_stall: assert property (c.state == ST_READ && c.haz && !c.haz_wait
    && op inside {OP_STM, OP_STR} && sidx == c.haz_idx |=> c.state == ST_READ) else $error("no load stall");
endmodule

// ### mem_model.sv
/*
  Word memory on the far side of the core's memory port.
  Assumes one request at a time, held until acknowledged.
*/
`timescale 1ns/1ps
module mem_model (
  input wire logic i_clk,
  input wire logic i_req,
  input wire logic i_we,
  input wire logic [31:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic [1:0] i_lat,
  output logic o_ack,
  output logic [31:0] o_rdata
);
  // ----------------------------------------
  // Storage and answer
  // ----------------------------------------
  logic [31:0] mem [0:255];
  logic [1:0] wait_cnt = 2'h0;
  logic [31:0] junk = 32'h5a5a_a5a5;
  int n_wr = 0;
  always @(posedge i_clk) begin
    junk <= {junk[30:0], junk[31] ^ junk[21]};
    o_rdata <= ~junk;
    o_ack <= 1'b0;
    if (i_req && !o_ack) begin
      if (wait_cnt == i_lat) begin
        o_ack <= 1'b1;
        wait_cnt <= 2'h0;
        if (i_we) begin
          mem[i_addr[9:2]] <= i_wdata;
          n_wr <= n_wr + 1;
        end else begin
          o_rdata <= mem[i_addr[9:2]];
        end
      end else begin
        wait_cnt <= wait_cnt + 2'h1;
      end
    end
  end
endmodule

// ### testbench.sv
/*
  Self-checking bench: runs short programs from the memory model.
  Assumes Wishbone access to control, PC and general registers.
*/
`timescale 1ns/1ps
module testbench;
  // ----------------------------------------
  // Signals and instances
  // ----------------------------------------
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0, wake = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h0;
  logic [1:0] lat = 2'h0;
  logic [31:0] wb_rd, mem_wd, mem_ad, mem_rd;
  logic wb_ack, wb_err, mem_req, mem_we, mem_ack, sleep, stby, err_seen;
  int n_fail = 0;
  int n_tests = 0;
  logic [7:0] sh_ops [14] = '{8'h04, 8'h05, 8'h24, 8'h25, 8'h20, 8'h21, 8'h00, 8'h01, 8'h08, 8'h09, 8'h18,
    8'h19, 8'h28, 8'h29};
  logic [34:0] tbl [15] = '{{16'h0008, 16'h8b03, 3'b100}, {16'h0018, 16'h8b03, 3'b000},
    {16'h0018, 16'h8903, 3'b100}, {16'h0008, 16'h8903, 3'b000}, {16'h0008, 16'h8f03, 3'b110},
    {16'h0018, 16'h8f03, 3'b010}, {16'h0018, 16'h8d03, 3'b110}, {16'h0008, 16'h8d03, 3'b010},
    {16'h0009, 16'ha003, 3'b110}, {16'h0009, 16'hb003, 3'b111}, {16'h0009, 16'h0723, 3'b110},
    {16'h0009, 16'h0703, 3'b111}, {16'h0009, 16'h482b, 3'b110}, {16'h0009, 16'h480b, 3'b111},
    {16'h482a, 16'h000b, 3'b110}};
  always #4 clk = ~clk;
  shift_branch_sysctl_exec i_dut (.i_clk(clk), .i_rst_n(rst_n), .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we),
    .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat), .o_wb_dat(wb_rd), .o_wb_ack(wb_ack), .o_wb_err(wb_err),
    .o_mem_req(mem_req), .o_mem_we(mem_we), .o_mem_addr(mem_ad), .o_mem_wdata(mem_wd), .i_mem_ack(mem_ack),
    .i_mem_rdata(mem_rd), .i_wake(wake), .o_sleep(sleep), .o_standby(stby));
  mem_model i_mem (.i_clk(clk), .i_req(mem_req), .i_we(mem_we), .i_addr(mem_ad), .i_wdata(mem_wd),
    .i_lat(lat), .o_ack(mem_ack), .o_rdata(mem_rd));
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic end_sim();
    if (n_fail == 0 && n_tests > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic cmp(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= 4'hf;
    do begin
      @(posedge clk);
    end while (wb_ack !== 1'b1 && wb_err !== 1'b1);
    q = wb_rd;
    err_seen = wb_err;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic gpr(input int i, input logic [31:0] v);
    logic [31:0] q;
    wb(1'b1, 8'(64 + 4 * i), v, q);
  endtask
  task automatic halt();
    logic [31:0] q;
    wb(1'b1, 8'h00, 32'h0, q);
    for (int n = 0; n < 30; n++) begin
      wb(1'b0, 8'h08, 32'h0, q);
      if (q[2] === 1'b0) break;
    end
    cmp("halted", 32'h0, {31'h0, q[2]});
  endtask
  task automatic run(input logic [15:0] p[$], input int nw, input logic sb);
    logic [31:0] q;
    int base;
    for (int i = 0; i < p.size(); i += 2) i_mem.mem[i / 2] = {p[i], p[i + 1]};
    gpr(2, 32'h200);
    gpr(6, 32'h300);
    lat <= 2'($urandom_range(3, 0));
    base = i_mem.n_wr;
    wb(1'b1, 8'h04, 32'h0, q);
    wb(1'b1, 8'h00, {30'h0, sb, 1'b1}, q);
    for (int n = 0; n < 800 && i_mem.n_wr < base + nw; n++) @(posedge clk);
    cmp("mem_writes", 32'(base + nw), 32'(i_mem.n_wr));
  endtask
  function automatic logic [32:0] shexp(input logic [7:0] op, input logic [31:0] v, input logic t);
    case (op)
      8'h04: return {v[31], v[30:0], v[31]};
      8'h05: return {v[0], v[0], v[31:1]};
      8'h24: return {v[31], v[30:0], t};
      8'h25: return {v[0], t, v[31:1]};
      8'h21: return {v[0], v[31], v[31:1]};
      8'h01: return {v[0], 1'b0, v[31:1]};
      8'h08: return {t, v << 2};
      8'h09: return {t, v >> 2};
      8'h18: return {t, v << 8};
      8'h19: return {t, v >> 8};
      8'h28: return {t, v << 16};
      8'h29: return {t, v >> 16};
      default: return {v[31], v[30:0], 1'b0};
    endcase
  endfunction
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    logic [31:0] q, v;
    logic [32:0] e;
    logic t;
    void'($urandom(63));
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    wb(1'b0, 8'h04, 32'h0, q);
    cmp("pc_reset", 32'h0, q);
    wb(1'b0, 8'h08, 32'h0, q);
    cmp("status_reset", 32'h0, q);
    wb(1'b0, 8'hfc, 32'h0, q);
    cmp("unmapped_err", 32'h1, {31'h0, err_seen});
    gpr(3, 32'h11);
    gpr(5, 32'h55);
    gpr(7, 32'h6);
    gpr(8, 32'he);
    for (int k = 0; k < 42; k++) begin
      v = (k < 14) ? (k[0] ? 32'h8000_0001 : 32'h7fff_fffe) : $urandom();
      t = 1'($urandom_range(1, 0));
      e = shexp(sh_ops[k % 14], v, t);
      gpr(1, v);
      i_mem.mem[8'h7f] = ~e[31:0];
      run('{t ? 16'h0018 : 16'h0008, {8'h41, sh_ops[k % 14]}, 16'h411a, 16'h4212, 16'haffe, 16'h0009}, 1, 1'b0);
      halt();
      cmp("shift_value", e[31:0], i_mem.mem[8'h7f]);
      wb(1'b0, 8'h08, 32'h0, q);
      cmp("shift_flag", {31'h0, e[32]}, {31'h0, q[0]});
    end
    for (int k = 0; k < 15; k++) begin
      i_mem.mem[8'h7f] = 32'hdead_beef;
      i_mem.mem[8'hbf] = 32'hdead_beef;
      run('{16'h451a, tbl[k][34:19], tbl[k][18:3], 16'h431a, 16'h4212, 16'haffe, 16'h0009, 16'h4612,
        16'haffe, 16'h0009}, 1, 1'b0);
      halt();
      cmp("fall_path", tbl[k][2] ? 32'hdead_beef : 32'h11, i_mem.mem[8'h7f]);
      cmp("target_path", !tbl[k][2] ? 32'hdead_beef : tbl[k][1] ? 32'h11 : 32'h55, i_mem.mem[8'hbf]);
      if (tbl[k][0]) begin
        wb(1'b0, 8'h10, 32'h0, q);
        cmp("return_addr", 32'h8, q);
      end
    end
    t = 1'($urandom_range(1, 0));
    i_mem.mem[8'h60] = 32'h3c0;
    i_mem.mem[8'h61] = {31'h0, t};
    i_mem.mem[8'hf2] = 32'h8;
    gpr(9, 32'h180);
    gpr(15, 32'h380);
    run('{16'h4927, 16'h4907, 16'h4223, 16'hc302, 16'haffe, 16'h0009}, 3, 1'b0);
    halt();
    cmp("ctrl_store", 32'h3c0, i_mem.mem[8'h7f]);
    cmp("trap_sr", {31'h0, t}, i_mem.mem[8'hdf]);
    cmp("trap_pc", 32'h8, i_mem.mem[8'hde]);
    wb(1'b0, 8'h14, 32'h0, q);
    cmp("sr_load", {31'h0, t}, q);
    gpr(9, 32'h188);
    gpr(15, 32'h378);
    v = $urandom();
    i_mem.mem[8'h62] = v;
    i_mem.mem[8'hde] = 32'h8;
    i_mem.mem[8'hdf] = {31'h0, !t};
    i_mem.mem[8'h7f] = 32'hdead_beef;
    run('{16'h002b, 16'h0009, 16'h0009, 16'h0009, 16'h4916, 16'h4212, 16'haffe, 16'h0009}, 1, 1'b0);
    halt();
    cmp("stall_load", v, i_mem.mem[8'h7f]);
    wb(1'b0, 8'h14, 32'h0, q);
    cmp("rte_sr", {31'h0, !t}, q);
    for (int k = 0; k < 2; k++) begin
      run('{16'h001b, 16'h0009, 16'haffe, 16'h0009}, 0, k[0]);
      for (int n = 0; n < 40 && sleep !== 1'b1; n++) @(posedge clk);
      cmp("sleep", 32'h1, {31'h0, sleep});
      cmp("standby", {31'h0, k[0]}, {31'h0, stby});
      v = 32'h0;
      repeat (8) begin
        @(posedge clk);
        v = v + {31'h0, mem_req};
      end
      cmp("sleep_idle", 32'h0, v);
      wake <= 1'b1;
      for (int n = 0; n < 40 && sleep !== 1'b0; n++) @(posedge clk);
      wake <= 1'b0;
      cmp("woken", 32'h0, {31'h0, sleep});
      halt();
    end
    end_sim();
  end
  initial begin
    #600us;
    n_fail++;
    end_sim();
  end
endmodule
